// ### design/frp_pkg.sv
// Purpose: Shared constants and types for the flash function and read parameter registers
// Assumes: Opcodes arrive MSB first, one bit per edge in SPI, one nibble per edge in QPI
// Notes: Read opcodes and the power-up persistent value are local choices

package frp_pkg;
   // Command opcodes
   localparam logic [7:0] OP_SET_READ_PARAMS_PERSISTENT = 8'h65;
   localparam logic [7:0] OP_SET_READ_PARAMS_VOLATILE = 8'hC0;
   localparam logic [7:0] OP_SET_READ_PARAMS_VOLATILE_ALT = 8'h63;
   localparam logic [7:0] OP_WRITE_FUNCTION = 8'h42;
   localparam logic [7:0] OP_READ_FUNCTION = 8'hB1;
   localparam logic [7:0] OP_READ_PARAMS = 8'hB2;

   // Frame bit counts and per-edge steps
   localparam logic [4:0] BITS_OPCODE = 5'h08;
   localparam logic [4:0] BITS_COMMAND = 5'h10;
   localparam logic [4:0] STEP_SPI = 5'h01;
   localparam logic [4:0] STEP_QPI = 5'h04;
   localparam logic [2:0] OUT_MSB = 3'h7;

   // Register layouts and reset values
   localparam logic [7:0] FUNC_OTP_MASK = 8'hF3;
   localparam logic [7:0] FUNC_RESET_BASE = 8'h00;
   localparam logic [7:0] READ_PARAMS_RESET = 8'h00;
   localparam logic [6:0] BURST_BASE_BYTES = 7'h08;

   // Data pin output enables
   localparam logic [3:0] IO_OE_OFF = 4'h0;
   localparam logic [3:0] IO_OE_SPI = 4'h2;
   localparam logic [3:0] IO_OE_QPI = 4'hF;

   // Function register, bit 7 down to bit 0
   typedef struct packed {
      logic [3:0] info_row_lock;
      logic erase_suspended_flag;
      logic program_suspended_flag;
      logic protect_area_bottom_select;
      logic dedicated_reset_disable;
   } frp_func_t;

   // Read parameter register, P7 down to P0
   typedef struct packed {
      logic hold_reset_select;
      logic [3:0] dummy_cycles;
      logic wrap_enable;
      logic [1:0] burst_length;
   } frp_rdpar_t;

   // Synchronised link pins
   typedef struct packed {
      logic sck;
      logic cs_n;
      logic [3:0] io;
   } frp_pins_t;

   // Role of the shared hold/reset pin
   typedef enum logic [1:0] {
      FRP_PIN_HOLD,
      FRP_PIN_RESET,
      FRP_PIN_IO3
   } frp_pin_role_t;

   // Command sequencer states
   typedef enum logic [2:0] {
      FRP_BOOT,
      FRP_IDLE,
      FRP_OPCODE,
      FRP_WDATA,
      FRP_RDATA,
      FRP_IGNORE
   } frp_state_t;
endpackage

// ### design/frp_pin_sync.sv
// Purpose: Two-stage synchroniser with edge detection for link pins
// Assumes: Pins change slower than a few clk_in periods
// Notes: First stage feeds only the second stage

`timescale 1ns/100ps

module frp_pin_sync #(
   parameter int unsigned W = 6,
   parameter logic [W-1:0] RESET_LEVEL = '0
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out,
   output logic [W-1:0] rise_out,
   output logic [W-1:0] fall_out
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
      logic [W-1:0] prev;
   } frp_sync_state_t;

   frp_sync_state_t st_r;
   frp_sync_state_t st_nxt;

   // Shift the pins through the stages
   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = async_in;
      st_nxt.sync = st_r.meta;
      st_nxt.prev = st_r.sync;
   end

   // Stages start at the pins' idle levels, so no false edge follows reset
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= '{meta: RESET_LEVEL, sync: RESET_LEVEL, prev: RESET_LEVEL};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Edges seen between the second and third stages
   assign sync_out = st_r.sync;
   assign rise_out = st_r.sync & ~st_r.prev;
   assign fall_out = ~st_r.sync & st_r.prev;
endmodule

// ### design/frp_feature_decode.sv
// Purpose: Turns function and read parameter bits into pin roles and read settings
// Assumes: Quad enable and QPI mode come from same-clock logic
// Notes: All outputs are registered

`timescale 1ns/100ps

module frp_feature_decode
   import frp_pkg::*;
#(
   parameter logic HAS_DEDICATED_RESET = 1'b1
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input frp_pkg::frp_func_t func_in,
   input frp_pkg::frp_rdpar_t rdpar_in,
   input wire logic quad_enable_in,
   input wire logic qpi_mode_in,
   output frp_pkg::frp_pin_role_t shared_pin_role_out,
   output logic wp_pin_is_io2_out,
   output logic dedicated_reset_enabled_out,
   output logic [3:0] dummy_cycles_out,
   output logic wrap_enable_out,
   output logic [6:0] burst_bytes_out
);
   import frp_pkg::*;

   typedef struct packed {
      frp_pin_role_t role;
      logic wp_io2;
      logic ded_en;
      logic [3:0] dummy;
      logic wrap;
      logic [6:0] burst;
   } frp_dec_state_t;

   frp_dec_state_t st_r;
   frp_dec_state_t st_nxt;

   // Burst length in bytes from the two-bit code
   function automatic logic [6:0] burst_bytes(input logic [1:0] code);
      burst_bytes = BURST_BASE_BYTES << code;
   endfunction

   // Pin role priority: data lines, then forced hold, then P7
   always_comb begin
      st_nxt = st_r;
      if (quad_enable_in || qpi_mode_in) begin
         st_nxt.role = FRP_PIN_IO3;
      end else if (HAS_DEDICATED_RESET && !func_in.dedicated_reset_disable) begin
         st_nxt.role = FRP_PIN_HOLD;
      end else if (rdpar_in.hold_reset_select) begin
         st_nxt.role = FRP_PIN_RESET;
      end else begin
         st_nxt.role = FRP_PIN_HOLD;
      end
      st_nxt.wp_io2 = quad_enable_in || qpi_mode_in;
      st_nxt.ded_en = HAS_DEDICATED_RESET && !func_in.dedicated_reset_disable;
      st_nxt.dummy = rdpar_in.dummy_cycles;
      st_nxt.wrap = rdpar_in.wrap_enable;
      st_nxt.burst = burst_bytes(rdpar_in.burst_length);
   end

   // Register the decoded settings
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= '{role: FRP_PIN_HOLD, wp_io2: 1'b0, ded_en: 1'b0, dummy: 4'h0,
                   wrap: 1'b0, burst: BURST_BASE_BYTES};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign shared_pin_role_out = st_r.role;
   assign wp_pin_is_io2_out = st_r.wp_io2;
   assign dedicated_reset_enabled_out = st_r.ded_en;
   assign dummy_cycles_out = st_r.dummy;
   assign wrap_enable_out = st_r.wrap;
   assign burst_bytes_out = st_r.burst;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_io3_role:
      assert property ((quad_enable_in || qpi_mode_in) |=> shared_pin_role_out == FRP_PIN_IO3)
      else $error("shared pin not IO3 under quad or QPI");
   a_hold_forced:
      assert property ((HAS_DEDICATED_RESET && !func_in.dedicated_reset_disable
                        && !quad_enable_in && !qpi_mode_in)
                       |=> shared_pin_role_out == FRP_PIN_HOLD)
      else $error("shared pin not hold while dedicated reset enabled");
   a_p7_select:
      assert property ((!quad_enable_in && !qpi_mode_in && rdpar_in.hold_reset_select
                        && (!HAS_DEDICATED_RESET || func_in.dedicated_reset_disable))
                       |=> shared_pin_role_out == FRP_PIN_RESET)
      else $error("P7 set but shared pin not reset");
   a_burst_len:
      assert property (##1 burst_bytes_out == burst_bytes($past(rdpar_in.burst_length)))
      else $error("burst length decode wrong");
endmodule

// ### design/frp_regs.sv
// Purpose: Function and read parameter registers behind an SPI/QPI command link
// Assumes: Link pins are asynchronous to clk_in; mode 0 sampling on SCK rise
// Notes: Persistent copy survives reload_in but not rst_n_in

`timescale 1ns/100ps

module frp_regs
   import frp_pkg::*;
#(
   parameter logic HAS_DEDICATED_RESET = 1'b1,
   parameter logic [7:0] PERSISTENT_INIT = READ_PARAMS_RESET
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic [3:0] io_in,
   input wire logic qpi_mode_in,
   input wire logic quad_enable_in,
   input wire logic write_enable_latch_in,
   input wire logic program_busy_in,
   input wire logic erase_busy_in,
   input wire logic suspend_cmd_in,
   input wire logic resume_cmd_in,
   input wire logic reload_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe_out,
   output frp_pkg::frp_func_t function_out,
   output frp_pkg::frp_rdpar_t read_params_out,
   output frp_pkg::frp_rdpar_t read_params_persistent_out,
   output frp_pkg::frp_pin_role_t shared_pin_role_out,
   output logic wp_pin_is_io2_out,
   output logic dedicated_reset_enabled_out,
   output logic [3:0] dummy_cycles_out,
   output logic wrap_enable_out,
   output logic [6:0] burst_bytes_out,
   output logic write_done_out
);
   import frp_pkg::*;

   // Function register reset value; bit 0 is one on parts without a dedicated pin
   localparam logic [7:0] FUNC_RESET = FUNC_RESET_BASE | {7'h00, ~HAS_DEDICATED_RESET};

   typedef struct packed {
      frp_state_t st;
      logic [7:0] opcode;
      logic [7:0] shift;
      logic [4:0] cnt;
      logic [2:0] out_idx;
      logic [3:0] io_drive;
      logic [3:0] io_oe;
      frp_func_t func;
      frp_rdpar_t nv;
      frp_rdpar_t vol;
      logic done;
   } frp_regs_state_t;

   frp_regs_state_t st_r;
   frp_regs_state_t st_nxt;
   frp_pins_t pin_sync;
   frp_pins_t pin_rise;
   frp_pins_t pin_fall;
   logic commit_func;
   logic commit_nv;
   logic commit_vol;
   logic [4:0] step;
   logic [7:0] sample;
   logic [7:0] rd_value;
   logic [7:0] func_bits;
   logic [7:0] otp_bits;

   // Bring link pins into the clk_in domain
   frp_pin_sync #(
      .W(6),
      .RESET_LEVEL(6'h1F)
   ) u_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .async_in({sck_in, cs_n_in, io_in}),
      .sync_out(pin_sync),
      .rise_out(pin_rise),
      .fall_out(pin_fall)
   );

   // Sequencer, register updates and suspend flags
   always_comb begin
      st_nxt = st_r;
      commit_func = 1'b0;
      commit_nv = 1'b0;
      commit_vol = 1'b0;
      func_bits = 8'h00;
      st_nxt.done = 1'b0;
      step = qpi_mode_in ? STEP_QPI : STEP_SPI;
      sample = qpi_mode_in ? {st_r.shift[3:0], pin_sync.io} : {st_r.shift[6:0], pin_sync.io[0]};
      rd_value = (st_r.opcode == OP_READ_FUNCTION) ? st_r.func : st_r.vol;

      // Resume clears the program suspension if flagged, else the erase one; a new suspend wins
      if (resume_cmd_in) begin
         if (st_r.func.program_suspended_flag) begin
            st_nxt.func.program_suspended_flag = 1'b0;
         end else begin
            st_nxt.func.erase_suspended_flag = 1'b0;
         end
      end
      if (suspend_cmd_in && program_busy_in) begin
         st_nxt.func.program_suspended_flag = 1'b1;
      end
      if (suspend_cmd_in && erase_busy_in) begin
         st_nxt.func.erase_suspended_flag = 1'b1;
      end
      if (reload_in) begin
         st_nxt.vol = st_r.nv;
      end

      unique case (st_r.st)
         FRP_BOOT: begin
            st_nxt.vol = st_r.nv;
            st_nxt.st = FRP_IDLE;
         end
         FRP_IDLE: begin
            if (pin_fall.cs_n) begin
               st_nxt.st = FRP_OPCODE;
               st_nxt.cnt = 5'h00;
            end
         end
         FRP_OPCODE: begin
            if (pin_rise.sck) begin
               st_nxt.shift = sample;
               st_nxt.cnt = st_r.cnt + step;
               if (st_nxt.cnt == BITS_OPCODE) begin
                  st_nxt.opcode = sample;
                  if (sample == OP_SET_READ_PARAMS_PERSISTENT
                      || sample == OP_SET_READ_PARAMS_VOLATILE
                      || sample == OP_SET_READ_PARAMS_VOLATILE_ALT
                      || sample == OP_WRITE_FUNCTION) begin
                     st_nxt.st = FRP_WDATA;
                  end else if (sample == OP_READ_FUNCTION || sample == OP_READ_PARAMS) begin
                     st_nxt.st = FRP_RDATA;
                     st_nxt.out_idx = OUT_MSB;
                  end else begin
                     st_nxt.st = FRP_IGNORE;
                  end
               end
            end
         end
         FRP_WDATA: begin
            if (pin_rise.sck) begin
               if (st_r.cnt == BITS_COMMAND) begin
                  st_nxt.st = FRP_IGNORE;
               end else begin
                  st_nxt.shift = sample;
                  st_nxt.cnt = st_r.cnt + step;
               end
            end
         end
         FRP_RDATA: begin
            // Drive on SCK fall, repeating the byte while CS stays low
            if (pin_fall.sck) begin
               if (qpi_mode_in) begin
                  st_nxt.io_drive = st_r.out_idx[2] ? rd_value[7:4] : rd_value[3:0];
                  st_nxt.io_oe = IO_OE_QPI;
               end else begin
                  st_nxt.io_drive = {2'b00, rd_value[st_r.out_idx], 1'b0};
                  st_nxt.io_oe = IO_OE_SPI;
               end
               st_nxt.out_idx = st_r.out_idx - step[2:0];
            end
         end
         FRP_IGNORE: begin
            st_nxt.st = FRP_IGNORE;
         end
      endcase

      // Chip select rise ends the frame and commits a complete write; all but OP_SET_READ_PARAMS_VOLATILE need write_enable_latch_in
      if (pin_rise.cs_n && st_r.st != FRP_BOOT) begin
         if (st_r.st == FRP_WDATA && st_r.cnt == BITS_COMMAND) begin
            commit_func = st_r.opcode == OP_WRITE_FUNCTION && write_enable_latch_in;
            commit_nv = st_r.opcode == OP_SET_READ_PARAMS_PERSISTENT && write_enable_latch_in;
            commit_vol = st_r.opcode == OP_SET_READ_PARAMS_VOLATILE
               || (st_r.opcode == OP_SET_READ_PARAMS_VOLATILE_ALT && write_enable_latch_in);
         end
         st_nxt.st = FRP_IDLE;
         st_nxt.io_oe = IO_OE_OFF;
         st_nxt.io_drive = 4'h0;
      end

      // One-time bits only ever gain ones; suspend flags ignore writes
      if (commit_func) begin
         func_bits = st_nxt.func;
         st_nxt.func = func_bits | (st_r.shift & FUNC_OTP_MASK);
      end
      if (commit_nv) begin
         st_nxt.nv = st_r.shift;
      end
      if (commit_vol) begin
         st_nxt.vol = st_r.shift;
      end
      st_nxt.done = commit_func || commit_nv || commit_vol;
   end

   // State register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= '{st: FRP_BOOT, opcode: 8'h00, shift: 8'h00, cnt: 5'h00, out_idx: OUT_MSB,
                   io_drive: 4'h0, io_oe: IO_OE_OFF, func: FUNC_RESET, nv: PERSISTENT_INIT,
                   vol: READ_PARAMS_RESET, done: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Pin roles and read settings from the live registers
   frp_feature_decode #(
      .HAS_DEDICATED_RESET(HAS_DEDICATED_RESET)
   ) u_decode (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .func_in(st_r.func),
      .rdpar_in(st_r.vol),
      .quad_enable_in(quad_enable_in),
      .qpi_mode_in(qpi_mode_in),
      .shared_pin_role_out(shared_pin_role_out),
      .wp_pin_is_io2_out(wp_pin_is_io2_out),
      .dedicated_reset_enabled_out(dedicated_reset_enabled_out),
      .dummy_cycles_out(dummy_cycles_out),
      .wrap_enable_out(wrap_enable_out),
      .burst_bytes_out(burst_bytes_out)
   );

   assign io_out = st_r.io_drive;
   assign io_oe_out = st_r.io_oe;
   assign function_out = st_r.func;
   assign read_params_out = st_r.vol;
   assign read_params_persistent_out = st_r.nv;
   assign write_done_out = st_r.done;
   assign otp_bits = st_r.func & FUNC_OTP_MASK;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_otp_sticky:
      assert property (##1 ((otp_bits & $past(otp_bits)) == $past(otp_bits)))
      else $error("one-time bit cleared");
   a_rst_dis_write:
      assert property ($rose(function_out.dedicated_reset_disable) |-> $past(commit_func))
      else $error("reset disable set without write");
   a_bottom_sticky:
      assert property (function_out.protect_area_bottom_select
                       |=> function_out.protect_area_bottom_select [*3])
      else $error("bottom select returned to top");
   a_lock_sticky:
      assert property (function_out.info_row_lock[0] |=> function_out.info_row_lock[0])
      else $error("row lock cleared");
   a_program_suspended_flag_set:
      assert property (suspend_cmd_in && program_busy_in
                       |=> function_out.program_suspended_flag)
      else $error("program suspend not flagged");
   a_program_suspended_flag_clear:
      assert property (resume_cmd_in && !suspend_cmd_in && function_out.program_suspended_flag
                       |=> !function_out.program_suspended_flag)
      else $error("program resume not cleared");
   a_erase_suspended_flag_set:
      assert property (suspend_cmd_in && erase_busy_in |=> function_out.erase_suspended_flag)
      else $error("erase suspend not flagged");
   a_boot_load:
      assert property (st_r.st == FRP_BOOT
                       |=> read_params_out == $past(read_params_persistent_out))
      else $error("volatile copy not loaded at power-up");
   a_vol_write:
      assert property (commit_vol |=> read_params_out == $past(st_r.shift)
                       && $stable(read_params_persistent_out)) // too
      else $error("volatile write wrong");
   a_nv_write:
      assert property (commit_nv && !reload_in |=> read_params_persistent_out == $past(st_r.shift)
                       && $stable(read_params_out))
      else $error("persistent write wrong");
   a_done_pulse:
      assert property (write_done_out |=> !write_done_out)
      else $error("write done longer than one cycle");
   a_sus_write_ro:
      assert property (commit_func && !suspend_cmd_in && !resume_cmd_in
                       |=> function_out[3:2] == $past(function_out[3:2]))
      else $error("suspend flags changed by a register write");
   a_ded_dis_sticky:
      assert property (function_out.dedicated_reset_disable
                       |=> function_out.dedicated_reset_disable)
      else $error("reset disable bit cleared");
endmodule

// ### test/frp_host_model.sv
// Purpose: Serial host that frames commands to the register block
// Assumes: Mode 0, SCK idles low between frames, 800 ns SCK period
// Notes: Released lines read high, as the pull-ups leave them

`timescale 1ns/100ps

module frp_host_model (
   input wire logic clk_in,
   input wire logic [3:0] bus_in,
   output logic sck_out,
   output logic cs_n_out,
   output logic [3:0] io_out
);
   // Idle link: select high, clock still, lines released
   initial begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      io_out = 4'hF;
   end

   // One frame; rd sends the opcode only and shifts a byte back
   task automatic frame(input logic [15:0] word, input logic qpi, input logic rd,
                        output logic [7:0] got);
      int n;
      n = qpi ? 4 : 16;
      if (rd) begin
         n = qpi ? 2 : 8;
      end
      got = 8'h00;
      @(posedge clk_in);
      #13;
      cs_n_out = 1'b0;
      #400;
      for (int i = 0; i < n; i++) begin
         io_out = qpi ? word[15-4*i -: 4] : {3'h7, word[15-i]};
         #400 sck_out = 1'b1;
         #400 sck_out = 1'b0;
      end
      io_out = 4'hF;
      // Read data is taken late in the high phase, well after the fall
      for (int i = 0; rd && i < (qpi ? 2 : 8); i++) begin
         #400 sck_out = 1'b1;
         #380 got = qpi ? {got[3:0], bus_in} : {got[6:0], bus_in[1]};
         #20 sck_out = 1'b0;
      end
      #400 cs_n_out = 1'b1;
      #800;
   endtask
endmodule

// ### test/flash_function_and_read_param_regs_tb_top.sv
// Purpose: Self-checking bench for the function and read parameter registers
// Assumes: Default parameters, dedicated reset pin present
// Notes: Register commands go through the host model over the serial link; suspend, resume and reload are pulsed directly

`timescale 1ns/100ps

module flash_function_and_read_param_regs_tb_top;
   import frp_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic qpi = 1'b0, quad = 1'b0, wel = 1'b0, pbusy = 1'b0, ebusy = 1'b0;
   logic sus = 1'b0, res = 1'b0, rel = 1'b0;
   logic sck, cs_n;
   logic [3:0] host_io, dev_io, dev_oe, io_bus;
   logic [7:0] got;
   frp_func_t func;
   frp_rdpar_t rp, rp_pers;
   frp_pin_role_t role;
   logic wp_io2, ded_en, wrap, done;
   logic [3:0] dummy;
   logic [6:0] burst;
   int failures = 0;
   int check_count = 0;
   int done_count = 0;

   // Clock and the wire level seen by both ends
   always #50 clk_in = ~clk_in;
   assign io_bus = (dev_oe & dev_io) | (~dev_oe & host_io);

   // Count cycles with the write done pulse high
   always @(posedge clk_in) begin
      if (done === 1'b1) begin
         done_count++;
      end
   end

   frp_host_model host (.clk_in(clk_in), .bus_in(io_bus), .sck_out(sck),
      .cs_n_out(cs_n), .io_out(host_io));

   frp_regs DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .sck_in(sck), .cs_n_in(cs_n),
      .io_in(io_bus), .qpi_mode_in(qpi), .quad_enable_in(quad),
      .write_enable_latch_in(wel), .program_busy_in(pbusy), .erase_busy_in(ebusy),
      .suspend_cmd_in(sus), .resume_cmd_in(res), .reload_in(rel), .io_out(dev_io),
      .io_oe_out(dev_oe), .function_out(func), .read_params_out(rp),
      .read_params_persistent_out(rp_pers), .shared_pin_role_out(role),
      .wp_pin_is_io2_out(wp_io2), .dedicated_reset_enabled_out(ded_en),
      .dummy_cycles_out(dummy), .wrap_enable_out(wrap), .burst_bytes_out(burst),
      .write_done_out(done));

   // Compare and count
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] op, input logic [7:0] dat);
      host.frame({op, dat}, qpi, 1'b0, got);
   endtask

   // One-cycle control pulses, then settle
   task automatic pulse(input logic s, input logic r, input logic l);
      @(posedge clk_in);
      sus <= s;
      res <= r;
      rel <= l;
      @(posedge clk_in);
      sus <= 1'b0;
      res <= 1'b0;
      rel <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask

   task automatic mode(input logic q, input logic p, input logic w);
      @(posedge clk_in);
      quad <= q;
      qpi <= p;
      wel <= w;
      repeat (3) @(posedge clk_in);
   endtask

   task automatic print_verdict();
      $display("Checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run
   initial begin
      repeat (40000) @(posedge clk_in);
      failures++;
      print_verdict();
   end

   initial begin
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (5) @(posedge clk_in);
      chk("func", func, 8'h00);
      chk("rp", rp, 8'h00);
      chk("burst", {1'b0, burst}, 8'h08);
      $display("reset test done");
      // Refused: alternate volatile opcode without write enable, unknown opcode
      wr(8'h63, 8'hFF);
      wr(8'h11, 8'hFF);
      chk("rp", rp, 8'h00);
      chk("done", 8'(done_count), 8'h00);
      // Volatile write needs no write enable
      wr(8'hC0, 8'h5A);
      chk("rp", rp, 8'h5A);
      chk("pers", rp_pers, 8'h00);
      chk("dummy", {4'h0, dummy}, 8'h0B);
      chk("wrap", {7'h0, wrap}, 8'h00);
      for (int k = 0; k < 4; k++) begin
         wr(8'hC0, 8'(k));
         chk("burst", {1'b0, burst}, 8'h08 << k);
      end
      chk("done", 8'(done_count), 8'h05);
      $display("volatile test done");
      wr(8'h65, 8'hA7);
      chk("pers", rp_pers, 8'h00);
      mode(1'b0, 1'b0, 1'b1);
      wr(8'h65, 8'hA7);
      chk("pers", rp_pers, 8'hA7);
      chk("rp", rp, 8'h03);
      wr(8'h63, 8'h84);
      chk("rp", rp, 8'h84);
      pulse(1'b0, 1'b0, 1'b1);
      chk("rp", rp, 8'hA7);
      chk("wrap", {7'h0, wrap}, 8'h01);
      chk("dummy", {4'h0, dummy}, 8'h04);
      chk("burst", {1'b0, burst}, 8'h40);
      $display("persistent test done");
      chk("role", {6'h0, role}, {6'h0, FRP_PIN_HOLD});
      chk("ded", {7'h0, ded_en}, 8'h01);
      mode(1'b1, 1'b0, 1'b1);
      chk("role", {6'h0, role}, {6'h0, FRP_PIN_IO3});
      chk("wp", {7'h0, wp_io2}, 8'h01);
      mode(1'b0, 1'b1, 1'b1);
      chk("role", {6'h0, role}, {6'h0, FRP_PIN_IO3});
      wr(8'hC0, 8'h3C);
      chk("rp", rp, 8'h3C);
      // Nibble-wide read back of the volatile copy
      host.frame({8'hB2, 8'h00}, qpi, 1'b1, got);
      chk("read rp", got, 8'h3C);
      mode(1'b0, 1'b0, 1'b1);
      $display("mode test done");
      wr(8'h42, 8'h02);
      chk("func", func, 8'h02);
      wr(8'h42, 8'h00);
      chk("func", func, 8'h02);
      wr(8'h42, 8'h0D);
      chk("func", func, 8'h03);
      wr(8'hC0, 8'h80);
      chk("role", {6'h0, role}, {6'h0, FRP_PIN_RESET});
      chk("ded", {7'h0, ded_en}, 8'h00);
      wr(8'hC0, 8'h00);
      chk("role", {6'h0, role}, {6'h0, FRP_PIN_HOLD});
      wr(8'h42, 8'hF0);
      chk("func", func, 8'hF3);
      wr(8'h42, 8'h00);
      host.frame({8'hB1, 8'h00}, 1'b0, 1'b1, got);
      chk("read func", got, 8'hF3);
      chk("oe", {4'h0, dev_oe}, 8'h00);
      $display("function test done");
      pbusy <= 1'b1;
      pulse(1'b1, 1'b0, 1'b0);
      chk("func", func, 8'hF7);
      pulse(1'b0, 1'b1, 1'b0);
      chk("func", func, 8'hF3);
      pbusy <= 1'b0;
      ebusy <= 1'b1;
      pulse(1'b1, 1'b0, 1'b0);
      chk("func", func, 8'hFB);
      pulse(1'b0, 1'b1, 1'b0);
      chk("func", func, 8'hF3);
      // Suspend and resume in one cycle: the suspend wins
      pulse(1'b1, 1'b1, 1'b0);
      chk("func", func, 8'hFB);
      pulse(1'b0, 1'b1, 1'b0);
      chk("func", func, 8'hF3);
      ebusy <= 1'b0;
      chk("done", 8'(done_count), 8'h0F);
      $display("suspend test done");
      print_verdict();
   end
endmodule
